// ---- hw/plc_link_cap_regs.sv ----
/*
 * Register bank of a root port: correctable error flag of device status,
 * the link capability dword and the L0s latency table behind it.
 * Assumes configuration requests and the error pulse come from logic on
 * clk_in, and that the common clock bit is a level from link control.
 */
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - flag sets on error, regardless of reporting
// - flag sets even when error masked
// - flag resets zero, clears by writing one
// - bits 31:24 read port index 02h
// - bit 20 link-active reporting reads zero
// - bit 19 surprise-down reporting reads zero
// - bit 18 zero, refclk must stay on
// - bits 17:15 write-once L1 latency, 010b
// - bits 14:12 read-only L0s latency, 100b
// - common clock bit picks L0s table entry
// - bits 11:10 write-once ASPM support, 11b
// - bits 9:4 read sixteen lanes, 10h
// - bits 3:0 read 2.5 Gb/s, 1h
// - common clock set means shared refclk
module plc_link_cap_regs (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire plc_pkg::plc_cfg_req_s cfg_req_in,
	input wire logic corr_err_detect_in,
	input wire logic common_refclk_config_in,
	output logic [31:0] cfg_rdata_out,
	output logic cfg_rvalid_out,
	output logic correctable_error_flag_out,
	output logic [2:0] l0s_exit_latency_out
);
	import plc_pkg::*;

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------

	// request hits the dword at the given offset
	function automatic logic plc_hit(input plc_cfg_req_s req, input logic [11:0] ofs);
		plc_hit = (req.addr[11:2] == ofs[11:2]);
	endfunction : plc_hit

	// L0s exit latency seen by the link for a given clock setting
	function automatic logic [2:0] plc_l0s_pick(input plc_state_s s, input logic common);
		plc_l0s_pick = common ? s.lat_common : s.lat_noncommon;
	endfunction : plc_l0s_pick

	// assemble the link capability dword
	function automatic logic [31:0] plc_link_cap(input plc_state_s s, input logic common);
		logic [31:0] w;
		w = 32'h00000000;
		w[PLC_PORT_LSB +: 8] = PLC_PORT_INDEX;
		w[PLC_LINK_ACTIVE_BIT] = PLC_LINK_ACTIVE_CAP;
		w[PLC_SURPRISE_DOWN_BIT] = PLC_SURPRISE_DOWN_CAP;
		w[PLC_REFCLK_TOL_BIT] = PLC_REFCLK_TOLERANT;
		w[PLC_L1_LAT_LSB +: 3] = s.l1_lat;
		w[PLC_L0S_LAT_LSB +: 3] = plc_l0s_pick(s, common);
		w[PLC_ASPM_LSB +: 2] = s.aspm;
		w[PLC_LANES_LSB +: 6] = PLC_MAX_LANES;
		w[PLC_SPEED_LSB +: 4] = PLC_MAX_SPEED;
		plc_link_cap = w;
	endfunction : plc_link_cap

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	plc_state_s state_q;
	plc_state_s state_d;
	logic wr_dev_sts;
	logic wr_link_cap;
	logic wr_table;
	logic ced_clear;

	// address decode of the current request
	assign wr_dev_sts = cfg_req_in.wr && plc_hit(cfg_req_in, PLC_OFS_DEV_CTL_STS);
	assign wr_link_cap = cfg_req_in.wr && plc_hit(cfg_req_in, PLC_OFS_LINK_CAP);
	assign wr_table = cfg_req_in.wr && plc_hit(cfg_req_in, PLC_OFS_L0S_TABLE);
	assign ced_clear = wr_dev_sts && cfg_req_in.be[PLC_CED_LANE] && cfg_req_in.wdata[PLC_CED_BIT];

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		state_d.rvalid = 1'b0;

		// error flag: detection sets regardless of enables or masks,
		// a one written clears, and a detection in that cycle wins
		if (corr_err_detect_in) begin
			state_d.ced = 1'b1;
		end else if (ced_clear) begin
			state_d.ced = 1'b0;
		end

		// L1 latency takes a write only when both lanes come together
		if (wr_link_cap && !state_q.l1_locked
			&& cfg_req_in.be[PLC_L1_LANE_LO] && cfg_req_in.be[PLC_L1_LANE_HI]) begin
			state_d.l1_lat = cfg_req_in.wdata[PLC_L1_LAT_LSB +: 3];
			state_d.l1_locked = 1'b1;
		end

		// ASPM support takes its first write, codes stored as written
		if (wr_link_cap && !state_q.aspm_locked && cfg_req_in.be[PLC_ASPM_LANE]) begin
			state_d.aspm = cfg_req_in.wdata[PLC_ASPM_LSB +: 2];
			state_d.aspm_locked = 1'b1;
		end

		// latency table, plain read-write per lane 0
		if (wr_table && cfg_req_in.be[0]) begin
			state_d.lat_noncommon = cfg_req_in.wdata[PLC_TBL_NONCOMMON_LSB +: 3];
			state_d.lat_common = cfg_req_in.wdata[PLC_TBL_COMMON_LSB +: 3];
		end

		// read data, one cycle after the request; unmapped reads zero
		if (cfg_req_in.rd) begin
			state_d.rvalid = 1'b1;
			state_d.rdata = 32'h00000000;
			if (plc_hit(cfg_req_in, PLC_OFS_DEV_CTL_STS)) begin
				state_d.rdata[PLC_CED_BIT] = state_q.ced;
			end else if (plc_hit(cfg_req_in, PLC_OFS_LINK_CAP)) begin
				state_d.rdata = plc_link_cap(state_q, common_refclk_config_in);
			end else if (plc_hit(cfg_req_in, PLC_OFS_L0S_TABLE)) begin
				state_d.rdata[PLC_TBL_NONCOMMON_LSB +: 3] = state_q.lat_noncommon;
				state_d.rdata[PLC_TBL_COMMON_LSB +: 3] = state_q.lat_common;
			end
		end
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------

	// synchronous reset to documented defaults
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_q.ced <= 1'b0;
			state_q.l1_lat <= PLC_L1_LAT_RST;
			state_q.aspm <= PLC_ASPM_RST;
			state_q.l1_locked <= 1'b0;
			state_q.aspm_locked <= 1'b0;
			state_q.lat_common <= PLC_TBL_COMMON_RST;
			state_q.lat_noncommon <= PLC_TBL_NONCOMMON_RST;
			state_q.rdata <= 32'h00000000;
			state_q.rvalid <= 1'b0;
		end else begin
			state_q <= state_d;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------

	// all from flops except the latency pick, a mux of flops
	assign cfg_rdata_out = state_q.rdata;
	assign cfg_rvalid_out = state_q.rvalid;
	assign correctable_error_flag_out = state_q.ced;
	assign l0s_exit_latency_out = plc_l0s_pick(state_q, common_refclk_config_in);

endmodule : plc_link_cap_regs

`default_nettype wire

// ---- hw/plc_pkg.sv ----
/*
 * Package for the port link capability register bank: configuration offsets,
 * field positions, reset values and the state carrier of the bank.
 * Assumes dword-aligned configuration accesses with four byte enables.
 */
package plc_pkg;

	// ------------------------------------------------------------------
	// configuration offsets (byte addresses of aligned dwords)
	// ------------------------------------------------------------------
	localparam int unsigned PLC_ADDR_W = 12;
	localparam logic [11:0] PLC_OFS_DEV_CTL_STS = 12'h0A8; // status in upper half
	localparam logic [11:0] PLC_OFS_LINK_CAP = 12'h0AC;
	localparam logic [11:0] PLC_OFS_L0S_TABLE = 12'h22C;

	// ------------------------------------------------------------------
	// device status field (dword at A8h, status word is bits 31:16)
	// ------------------------------------------------------------------
	localparam int unsigned PLC_CED_BIT = 16; // status bit 0
	localparam int unsigned PLC_CED_LANE = 2;

	// ------------------------------------------------------------------
	// link capability fields
	// ------------------------------------------------------------------
	localparam int unsigned PLC_PORT_LSB = 24;
	localparam int unsigned PLC_LINK_ACTIVE_BIT = 20;
	localparam int unsigned PLC_SURPRISE_DOWN_BIT = 19;
	localparam int unsigned PLC_REFCLK_TOL_BIT = 18;
	localparam int unsigned PLC_L1_LAT_LSB = 15;
	localparam int unsigned PLC_L0S_LAT_LSB = 12;
	localparam int unsigned PLC_ASPM_LSB = 10;
	localparam int unsigned PLC_LANES_LSB = 4;
	localparam int unsigned PLC_SPEED_LSB = 0;
	localparam int unsigned PLC_L1_LANE_LO = 1; // bit 15
	localparam int unsigned PLC_L1_LANE_HI = 2; // bits 17:16
	localparam int unsigned PLC_ASPM_LANE = 1;

	localparam logic [7:0] PLC_PORT_INDEX = 8'h02;
	localparam logic PLC_LINK_ACTIVE_CAP = 1'b0;
	localparam logic PLC_SURPRISE_DOWN_CAP = 1'b0;
	localparam logic PLC_REFCLK_TOLERANT = 1'b0;
	localparam logic [2:0] PLC_L1_LAT_RST = 3'h2; // 2 us to under 4 us
	localparam logic [2:0] PLC_L0S_LAT_RST = 3'h4; // 512 ns to under 1 us
	localparam logic [1:0] PLC_ASPM_RST = 2'h3; // L1 and L0s
	localparam logic [5:0] PLC_MAX_LANES = 6'h10; // sixteen lanes
	localparam logic [3:0] PLC_MAX_SPEED = 4'h1; // 2.5 Gb/s
	localparam logic [31:0] PLC_LINK_CAP_RST = 32'h02014D01;

	// ------------------------------------------------------------------
	// L0s latency table at 22Ch
	// ------------------------------------------------------------------
	localparam int unsigned PLC_TBL_NONCOMMON_LSB = 0;
	localparam int unsigned PLC_TBL_COMMON_LSB = 3;
	localparam logic [2:0] PLC_TBL_NONCOMMON_RST = 3'h4;
	localparam logic [2:0] PLC_TBL_COMMON_RST = 3'h4;

	// ------------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic rd;
		logic wr;
		logic [11:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} plc_cfg_req_s;

	typedef struct packed {
		logic ced;
		logic [2:0] l1_lat;
		logic [1:0] aspm;
		logic l1_locked;
		logic aspm_locked;
		logic [2:0] lat_common;
		logic [2:0] lat_noncommon;
		logic [31:0] rdata;
		logic rvalid;
	} plc_state_s;

endpackage : plc_pkg

// ---- tb/plc_props.sv ----
/* assertions on the link capability bank ports; bound to plc_link_cap_regs */
`timescale 1ns/1ns
`default_nettype none
module plc_props (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire plc_pkg::plc_cfg_req_s cfg_req_in,
	input wire logic corr_err_detect_in,
	input wire logic common_refclk_config_in,
	input wire logic [31:0] cfg_rdata_out,
	input wire logic cfg_rvalid_out,
	input wire logic correctable_error_flag_out,
	input wire logic [2:0] l0s_exit_latency_out
);
	import plc_pkg::*;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	logic cap_rd;
	logic clr;
	logic flag;
	// decoded capability read and flag clear
	assign cap_rd = cfg_req_in.rd && cfg_req_in.addr[11:2] == PLC_OFS_LINK_CAP[11:2];
	assign clr = cfg_req_in.wr && cfg_req_in.addr[11:2] == PLC_OFS_DEV_CTL_STS[11:2] && cfg_req_in.be[2]
		&& cfg_req_in.wdata[16];
	assign flag = correctable_error_flag_out;
	sequence s_quiet_wr;
		!cfg_req_in.wr ##1 $stable(common_refclk_config_in);
	endsequence
	property p_set; corr_err_detect_in |=> flag; endproperty
	property p_hold; flag && !clr |=> flag; endproperty
	property p_clr; clr && !corr_err_detect_in |=> !flag; endproperty
	property p_rise; !flag && !corr_err_detect_in |=> !flag; endproperty
	property p_hi; cap_rd |=> cfg_rvalid_out && cfg_rdata_out[31:18] == {PLC_PORT_INDEX, 6'h00}; endproperty
	property p_lo; cap_rd |=> cfg_rdata_out[9:0] == {PLC_MAX_LANES, PLC_MAX_SPEED}; endproperty
	property p_l0s; cap_rd |=> cfg_rdata_out[14:12] == $past(l0s_exit_latency_out); endproperty
	property p_mux; s_quiet_wr |-> $stable(l0s_exit_latency_out); endproperty
	a_set: assert property (p_set) else $error("flag not set on error");
	a_hold: assert property (p_hold) else $error("flag lost");
	a_clr: assert property (p_clr) else $error("flag not cleared");
	a_rise: assert property (p_rise) else $error("flag set without error");
	a_hi: assert property (p_hi) else $error("upper capability bits wrong");
	a_lo: assert property (p_lo) else $error("lane or speed wrong");
	a_l0s: assert property (p_l0s) else $error("latency field mismatch");
	a_mux: assert property (p_mux) else $error("latency moved");
endmodule : plc_props
bind plc_link_cap_regs plc_props u_props (.clk_in(clk_in), .rst_n_in(rst_n_in), .cfg_req_in(cfg_req_in),
	.corr_err_detect_in(corr_err_detect_in), .common_refclk_config_in(common_refclk_config_in),
	.cfg_rdata_out(cfg_rdata_out), .cfg_rvalid_out(cfg_rvalid_out),
	.correctable_error_flag_out(correctable_error_flag_out), .l0s_exit_latency_out(l0s_exit_latency_out));
`default_nettype wire

// ---- tb/plc_link_partner.sv ----
/* link partner stand-in: reports errors and the clocking set-up; bench drives it */
`timescale 1ns/1ns
`default_nettype none
module plc_link_partner (
	input wire logic err_req_in,
	input wire logic shared_refclk_in,
	output logic corr_err_out,
	output logic common_cfg_out
);
	// reference clock never removed, so zero tolerance suits
	assign corr_err_out = err_req_in;
	assign common_cfg_out = shared_refclk_in;
endmodule : plc_link_partner
`default_nettype wire

// ---- tb/testbench.sv ----
/* self-checking bench of the link capability bank; drives at falling edge */
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import plc_pkg::*;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	plc_cfg_req_s req = '0;
	logic err_req = 1'b0;
	logic shared = 1'b0;
	logic corr_err, common_cfg, rvalid, flag;
	logic [31:0] rdata;
	logic [31:0] seed = 32'h90EE;
	logic [2:0] l0s;
	logic [2:0] l1 = 3'h2;
	logic [2:0] lat_n = 3'h4;
	logic [2:0] lat_c = 3'h4;
	int errors = 0;
	int num_checks = 0;
	always #4 clk_in = ~clk_in;
	plc_link_partner u_plc_link_partner (.err_req_in(err_req), .shared_refclk_in(shared),
		.corr_err_out(corr_err), .common_cfg_out(common_cfg));
	plc_link_cap_regs u_plc_link_cap_regs (.clk_in(clk_in), .rst_n_in(rst_n_in), .cfg_req_in(req),
		.corr_err_detect_in(corr_err), .common_refclk_config_in(common_cfg), .cfg_rdata_out(rdata),
		.cfg_rvalid_out(rvalid), .correctable_error_flag_out(flag), .l0s_exit_latency_out(l0s));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [31:0] cap(input logic [2:0] a, input logic [2:0] b, input logic [1:0] c);
		return {PLC_PORT_INDEX, 6'h00, a, b, c, PLC_MAX_LANES, PLC_MAX_SPEED};
	endfunction : cap
	function automatic logic [31:0] fld(input logic [31:0] r, input logic [2:0] a, input logic [1:0] c);
		return (r & ~32'h0003_8C00) | {14'h0, a, 3'h0, c, 10'h0};
	endfunction : fld
	task check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check
	task wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d, input logic e);
		@(negedge clk_in);
		req.wr = 1'b1; req.addr = a; req.be = be; req.wdata = d; err_req = e;
		@(negedge clk_in);
		req.wr = 1'b0; err_req = 1'b0;
	endtask : wr
	task rd(input logic [11:0] a, input logic [31:0] exp);
		@(negedge clk_in);
		req.rd = 1'b1; req.addr = a;
		@(negedge clk_in);
		req.rd = 1'b0;
		check({31'h0, rvalid}, 32'h1);
		check(rdata, exp);
	endtask : rd
	task print_verdict;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : print_verdict
	initial begin
		#200000;
		errors++;
		print_verdict();
	end
	initial begin
		repeat (2) @(negedge clk_in);
		rst_n_in = 1'b1;
		rd(PLC_OFS_LINK_CAP, PLC_LINK_CAP_RST);
		rd(12'h100, 32'h0);
		// half write: only the support field may land
		seed = lfsr(seed);
		wr(PLC_OFS_LINK_CAP, 4'h2, fld(seed, 3'h7, 2'h1), 1'b0);
		rd(PLC_OFS_LINK_CAP, cap(l1, lat_n, 2'h1));
		seed = lfsr(seed);
		l1 = seed[2:0];
		wr(PLC_OFS_LINK_CAP, 4'hF, fld(seed, l1, 2'h2), 1'b0);
		rd(PLC_OFS_LINK_CAP, cap(l1, lat_n, 2'h1));
		wr(PLC_OFS_LINK_CAP, 4'hF, fld(~seed, ~l1, 2'h3), 1'b0);
		rd(PLC_OFS_LINK_CAP, cap(l1, lat_n, 2'h1));
		// latency table under both clock set-ups
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			wr(PLC_OFS_L0S_TABLE, 4'h1, seed, 1'b0);
			lat_n = seed[2:0];
			lat_c = seed[5:3];
			shared = seed[7];
			rd(PLC_OFS_LINK_CAP, cap(l1, shared ? lat_c : lat_n, 2'h1));
			check({29'h0, l0s}, {29'h0, shared ? lat_c : lat_n});
		end
		// error flag set, clear attempts, race
		wr(PLC_OFS_DEV_CTL_STS, 4'h0, 32'h0, 1'b1);
		rd(PLC_OFS_DEV_CTL_STS, 32'h0001_0000);
		wr(PLC_OFS_DEV_CTL_STS, 4'hB, 32'hFFFF_FFFF, 1'b0);
		check({31'h0, flag}, 32'h1);
		wr(PLC_OFS_DEV_CTL_STS, 4'hF, 32'hFFFE_FFFF, 1'b0);
		check({31'h0, flag}, 32'h1);
		wr(PLC_OFS_DEV_CTL_STS, 4'h4, 32'h0001_0000, 1'b1);
		check({31'h0, flag}, 32'h1);
		wr(PLC_OFS_DEV_CTL_STS, 4'h4, 32'h0001_0000, 1'b0);
		check({31'h0, flag}, 32'h0);
		// second reset unlocks the write-once fields
		@(negedge clk_in);
		rst_n_in = 1'b0;
		@(negedge clk_in);
		rst_n_in = 1'b1;
		rd(PLC_OFS_LINK_CAP, PLC_LINK_CAP_RST);
		wr(PLC_OFS_LINK_CAP, 4'h6, fld(seed, 3'h5, 2'h1), 1'b0);
		rd(PLC_OFS_LINK_CAP, cap(3'h5, 3'h4, 2'h1));
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
